// file: shared/svmon_regs.svh
`ifndef SVMON_REGS_SVH
`define SVMON_REGS_SVH
// Overview of operation
// - bits 7 and 6 of control read zero; writes to them are ignored.
// - bit 5 is read-only; set once internal reference has settled.
// - bit 4 powers the detector up when one, down when zero.
// - trip select code 1111 routes the external input pin to the comparator.
// - codes 0001 to 1110 pick internal levels; code 0000 is reserved.
// - control resets to stable and enable clear, trip select 0101.
// - any device reset returns all detector state to reset values.
// - low supply flag is never raised before the reference is stable.
// - stabilization timing comes from the analog reference, not a clock count.
// - clearing the flag while supply is still low leaves it set.
// - detector works in sleep; a trip sets the flag and wakes the device.
// - after wake, vector only if global interrupts are enabled.
// - the settling wait applies only if the shared reference was not running.
// - flag sets when the selected divided tap falls below the set point.

`define SVMON_ADDR_CTRL      12'h000
`define SVMON_ADDR_STATUS    12'h004
`define SVMON_ADDR_CLEAR     12'h008
`define SVMON_ADDR_IRQ_EN    12'h00c
`define SVMON_CTRL_STABLE    5
`define SVMON_CTRL_ENABLE    4
`define SVMON_CTRL_TRIP_MSB  3
`define SVMON_CTRL_RESET     8'h05
`define SVMON_TRIP_EXTERNAL  4'hf
`define SVMON_TRIP_RESERVED  4'h0
`define SVMON_EVT_LOW        0
`define SVMON_EVT_STABLE     1
`define SVMON_EVT_BAD_TRIP   2
`define SVMON_NUM_EVT        3
`endif

// file: shared/svmon_pkg.sv
package svmon_pkg;
  typedef enum logic [1:0] {
    SVMON_OFF,
    SVMON_SETTLE,
    SVMON_ACTIVE
  } svmon_state_type;
endpackage : svmon_pkg

// file: hw/svmon_sync.sv
module svmon_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : svmon_sync

// file: hw/svmon_ctrl.sv
// Chosen here: the APB slave port and the placing of the registers.
`include "svmon_regs.svh"
module svmon_ctrl
  import svmon_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_running,
  input  wire logic        ref_settled,
  input  wire logic        comp_low,
  input  wire logic        sleep_mode,
  input  wire logic        global_irq_enable,
  output logic             detector_power_enable,
  output logic      [3:0]  trip_point_select,
  output logic             external_trip_input_sel,
  output logic             irq,
  output logic             wake_req,
  output logic             vector_take
);

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       acc     = psel && penable;
  wire       wr_acc  = acc && pwrite;
  wire       hit_ctl = paddr == `SVMON_ADDR_CTRL;
  wire       hit_sts = paddr == `SVMON_ADDR_STATUS;
  wire       hit_clr = paddr == `SVMON_ADDR_CLEAR;
  wire       hit_ien = paddr == `SVMON_ADDR_IRQ_EN;
  wire       mapped  = hit_ctl || hit_sts || hit_clr || hit_ien;
  wire       wr_ctl  = wr_acc && hit_ctl;
  wire       wr_clr  = wr_acc && hit_clr;
  wire       wr_ien  = wr_acc && hit_ien;

  logic                        enable_ff;
  logic [3:0]                  trip_ff;
  logic                        stable_ff;
  logic [`SVMON_NUM_EVT-1:0]   status_ff;
  logic [`SVMON_NUM_EVT-1:0]   irq_en_ff;
  svmon_state_type             state_ff;
  svmon_state_type             nxt_state;
  logic                        low_sync;

  //////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_ff <= 1'b0;
      trip_ff   <= 4'(`SVMON_CTRL_RESET);
    end else if (wr_ctl) begin
      enable_ff <= pwdata[`SVMON_CTRL_ENABLE];
      trip_ff   <= pwdata[`SVMON_CTRL_TRIP_MSB:0];
    end
  end

  wire [7:0] ctrl_rd = {2'b00, stable_ff, enable_ff, trip_ff};

  //////////////////////////////////////////////////////////////////////////////
  // reference settling: waits on the analog ready, no cycle count
  wire ref_ok = ref_running || ref_settled;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SVMON_OFF:    if (enable_ff) nxt_state = ref_ok ? SVMON_ACTIVE : SVMON_SETTLE;
      SVMON_SETTLE: if (!enable_ff) nxt_state = SVMON_OFF;
                    else if (ref_ok) nxt_state = SVMON_ACTIVE;
      SVMON_ACTIVE: if (!enable_ff) nxt_state = SVMON_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff  <= SVMON_OFF;
      stable_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      stable_ff <= nxt_state == SVMON_ACTIVE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparator path
  svmon_sync u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (comp_low),
    .sync_out (low_sync)
  );

  wire low_evt    = low_sync && stable_ff && enable_ff;
  wire stable_evt = (nxt_state == SVMON_ACTIVE) && !stable_ff;
  wire bad_evt    = wr_ctl && (pwdata[`SVMON_CTRL_TRIP_MSB:0] == `SVMON_TRIP_RESERVED);
  wire [`SVMON_NUM_EVT-1:0] evt = {bad_evt, stable_evt, low_evt};
  wire [`SVMON_NUM_EVT-1:0] clr = wr_clr ? pwdata[`SVMON_NUM_EVT-1:0] : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= '0;
      irq_en_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~clr) | evt;
      if (wr_ien) irq_en_ff <= pwdata[`SVMON_NUM_EVT-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  wire        pend    = |(status_ff & irq_en_ff);
  wire        low_pend = status_ff[`SVMON_EVT_LOW] && irq_en_ff[`SVMON_EVT_LOW];
  wire [31:0] rd_mux  = hit_ctl ? {24'h0, ctrl_rd} :
                        hit_sts ? {29'h0, status_ff} :
                        hit_ien ? {29'h0, irq_en_ff} : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata                  <= 32'h0;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      detector_power_enable   <= 1'b0;
      trip_point_select       <= 4'(`SVMON_CTRL_RESET);
      external_trip_input_sel <= 1'b0;
      irq                     <= 1'b0;
      wake_req                <= 1'b0;
      vector_take             <= 1'b0;
    end else begin
      pready                  <= psel && !penable;
      pslverr                 <= psel && !penable && !mapped;
      prdata                  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      detector_power_enable   <= enable_ff;
      trip_point_select       <= trip_ff;
      external_trip_input_sel <= trip_ff == `SVMON_TRIP_EXTERNAL;
      irq                     <= pend;
      wake_req                <= sleep_mode && status_ff[`SVMON_EVT_LOW];
      vector_take             <= sleep_mode && low_pend && global_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_clear_low;
    wr_clr && pwdata[`SVMON_EVT_LOW];
  endsequence
  sequence s_low_now;
    low_evt;
  endsequence

  chk_unused_zero: assert property (@(posedge clk) disable iff (!rstn) ctrl_rd[7:6] == 2'b00)
    else $error("unused control bits not zero");
  chk_stable_needs_ref: assert property (@(posedge clk) disable iff (!rstn)
    $rose(stable_ff) |-> $past(enable_ff) && $past(ref_ok))
    else $error("stable flag rose without reference");
  chk_power_follows: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl |=> ##1 detector_power_enable == $past(pwdata[`SVMON_CTRL_ENABLE], 2))
    else $error("power enable output wrong");
  chk_ext_select: assert property (@(posedge clk) disable iff (!rstn)
    external_trip_input_sel == ($past(trip_ff) == `SVMON_TRIP_EXTERNAL))
    else $error("external select mismatch");
  chk_reserved_flag: assert property (@(posedge clk) disable iff (!rstn)
    bad_evt |=> status_ff[`SVMON_EVT_BAD_TRIP])
    else $error("reserved trip not flagged");
  chk_no_early_flag: assert property (@(posedge clk) disable iff (!rstn)
    !stable_ff && !$past(status_ff[`SVMON_EVT_LOW]) && !wr_ctl |=> !status_ff[`SVMON_EVT_LOW] || $past(low_evt))
    else $error("low flag set before stable");
  chk_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    s_clear_low and s_low_now |=> status_ff[`SVMON_EVT_LOW])
    else $error("clear overrode low condition");
  chk_sleep_wake: assert property (@(posedge clk) disable iff (!rstn)
    sleep_mode && status_ff[`SVMON_EVT_LOW] |=> wake_req)
    else $error("no wake on low supply");
  chk_vector_gie: assert property (@(posedge clk) disable iff (!rstn)
    vector_take |-> $past(global_irq_enable))
    else $error("vector taken without global enable");
  chk_sync_path: assert property (@(posedge clk) disable iff (!rstn)
    (stable_ff && enable_ff && comp_low) [*3] |=> status_ff[`SVMON_EVT_LOW])
    else $error("synchronized low not flagged");
endmodule : svmon_ctrl

// file: testbench/svmon_tb.sv
`include "svmon_regs.svh"
module tb
  import svmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        ref_running, ref_settled, comp_low, sleep_mode, global_irq_enable;
  logic        power_en, ext_sel, irq, wake_req, vector_take;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic [3:0]  trip;
  int          failures, n_compared, m_ctrl;

  svmon_ctrl svmon_ctrl_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_running(ref_running), .ref_settled(ref_settled), .comp_low(comp_low), .sleep_mode(sleep_mode),
    .global_irq_enable(global_irq_enable), .detector_power_enable(power_en), .trip_point_select(trip),
    .external_trip_input_sel(ext_sel), .irq(irq), .wake_req(wake_req), .vector_take(vector_take));

  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one transfer; held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll_stable;
    int n;
    n = 0;
    do apb(1'b0, `SVMON_ADDR_CTRL, 32'h0); while (rd[5] !== 1'b1 && n++ < 20);
  endtask : poll_stable

  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    {clk, rstn, psel, penable, pwrite, ref_running, ref_settled, comp_low, sleep_mode, global_irq_enable} = '0;
    paddr = '0;
    pwdata = '0;
    lf = 32'h0114;
    m_ctrl = 'h05;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `SVMON_ADDR_CTRL, 32'h0);
    chk(rd, 32'(m_ctrl));
    chk(32'({power_en, trip}), 32'h05);
    $display("reset values done");
    for (int c = 0; c < 16; c++) begin
      lf = lfsr(lf);
      apb(1'b1, `SVMON_ADDR_CTRL, {lf[31:5], 1'b0, c[3:0]});
      m_ctrl = c;
      repeat (2) @(negedge clk);
      chk(32'({ext_sel, trip}), 32'({c == 15, c[3:0]}));
      apb(1'b0, `SVMON_ADDR_CTRL, 32'h0);
      chk(rd, 32'(m_ctrl));
    end
    apb(1'b1, `SVMON_ADDR_STATUS, 32'h0);
    apb(1'b0, `SVMON_ADDR_STATUS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, `SVMON_ADDR_CLEAR, 32'h7);
    $display("trip codes done");
    comp_low <= 1'b1;
    apb(1'b1, `SVMON_ADDR_CTRL, 32'h1e);
    repeat (8) @(posedge clk);
    apb(1'b0, `SVMON_ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `SVMON_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1e);
    chk(32'(power_en), 32'h1);
    ref_settled <= 1'b1;
    poll_stable();
    chk(rd, 32'h3e);
    repeat (4) @(posedge clk);
    apb(1'b1, `SVMON_ADDR_CLEAR, 32'h7);
    apb(1'b0, `SVMON_ADDR_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `SVMON_ADDR_IRQ_EN, 32'h1);
    sleep_mode <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({irq, wake_req, vector_take}), 32'h6);
    @(posedge clk) global_irq_enable <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({wake_req, vector_take}), 32'h3);
    apb(1'b1, `SVMON_ADDR_IRQ_EN, 32'h0);
    comp_low <= 1'b0;
    sleep_mode <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b1, `SVMON_ADDR_CLEAR, 32'h1);
    apb(1'b0, `SVMON_ADDR_STATUS, 32'h0);
    chk(32'({irq, rd[2:0]}), 32'h0);
    $display("detect and sleep done");
    apb(1'b1, 12'h010, 32'hff);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    rstn <= 1'b0;
    ref_settled <= 1'b0;
    ref_running <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `SVMON_ADDR_CTRL, 32'h0);
    chk(rd, 32'h05);
    apb(1'b1, `SVMON_ADDR_CTRL, 32'h13);
    poll_stable();
    chk(rd, 32'h33);
    apb(1'b1, `SVMON_ADDR_CTRL, 32'h03);
    repeat (2) @(negedge clk);
    chk(32'(power_en), 32'h0);
    $display("reset and shared reference done");
    end_of_test();
  end
endmodule : tb
